// >>> src/lmc_dev.sv
// controller end: answers the move count read over the byte link
`timescale 1ns/1ps
module lmc_dev
  import lmc_pkg::*;
#(
  parameter int BYTE_GAP = LMC_BYTE_GAP,
  parameter int SILENCE = LMC_SILENCE
) (
  input wire logic clock,
  input wire logic rst_n,
  lmc_link_if.dev link,
  input wire logic [3:0] axis_no,
  input wire logic [31:0] lifetime_move_count,
  output logic reply_busy
);
  if (BYTE_GAP < 1 || SILENCE <= BYTE_GAP || SILENCE > 255) begin : g_chk
    $error("lmc_dev: gap and silence counts out of range");
  end

  typedef enum logic {D_RX, D_TX} lmc_dst_t;
  typedef struct packed {
    lmc_dst_t st;
    logic [7:0][7:0] rbuf;
    logic [3:0] nb;
    logic [7:0] idle;
    logic [15:0] crc;
    logic [31:0] cnt;
    logic [3:0] tidx;
    logic [7:0] gap;
    logic vld;
    logic [7:0] dout;
  } lmc_dstate_t;

  lmc_dstate_t s_q, s_d;
  logic [7:0] tx_byte;
  logic q_ok;

  // reply byte by position; check bytes go low first
  always_comb begin
    unique case (s_q.tidx)
      4'd0: tx_byte = lmc_axis_addr(axis_no);
      4'd1: tx_byte = LMC_FUNC_READ;
      4'd2: tx_byte = LMC_BYTE_COUNT;
      4'd3: tx_byte = s_q.cnt[31:24];
      4'd4: tx_byte = s_q.cnt[23:16];
      4'd5: tx_byte = s_q.cnt[15:8];
      4'd6: tx_byte = s_q.cnt[7:0];
      4'd7: tx_byte = s_q.crc[7:0];
      default: tx_byte = s_q.crc[15:8];
    endcase
  end

  // a residue of zero over data plus check means the check matched
  assign q_ok = s_q.nb == LMC_QUERY_LEN && s_q.crc == 16'h0000
    && s_q.rbuf[0] == lmc_axis_addr(axis_no)
    && s_q.rbuf[1] == LMC_FUNC_READ
    && {s_q.rbuf[2], s_q.rbuf[3]} == LMC_REG_HIGH
    && {s_q.rbuf[4], s_q.rbuf[5]} == LMC_REG_QTY;

  always_comb begin
    s_d = s_q;
    s_d.vld = 1'b0;
    unique case (s_q.st)
      D_RX: begin
        if (link.q_vld) begin
          if (s_q.nb < LMC_QUERY_LEN) begin
            s_d.rbuf[s_q.nb[2:0]] = link.q_byte;
          end
          if (s_q.nb != 4'hf) begin
            s_d.nb = s_q.nb + 4'h1;
          end
          s_d.crc = lmc_crc_step(s_q.crc, link.q_byte);
          s_d.idle = 8'h00;
        end else if (s_q.nb != 4'h0) begin
          s_d.idle = s_q.idle + 8'h01;
          // frame ends only after a full silence; runt or long frames drop
          if (s_q.idle == 8'(SILENCE - 1)) begin
            s_d.nb = 4'h0;
            s_d.idle = 8'h00;
            s_d.crc = LMC_CRC_INIT;
            if (q_ok) begin
              s_d.st = D_TX;
              s_d.cnt = lifetime_move_count;
              s_d.tidx = 4'h0;
              s_d.gap = 8'h00;
            end
          end
        end
      end
      D_TX: begin
        // query bytes arriving while replying are ignored
        if (s_q.gap != 8'h00) begin
          s_d.gap = s_q.gap - 8'h01;
        end else if (s_q.tidx == LMC_RESP_LEN) begin
          s_d.st = D_RX; // trailing silence elapsed
          s_d.crc = LMC_CRC_INIT;
        end else begin
          s_d.vld = 1'b1;
          s_d.dout = tx_byte;
          if (s_q.tidx < 4'd7) begin
            s_d.crc = lmc_crc_step(s_q.crc, tx_byte);
          end
          s_d.tidx = s_q.tidx + 4'h1;
          s_d.gap = (s_q.tidx == LMC_RESP_LEN - 4'h1) ?
            8'(SILENCE) : 8'(BYTE_GAP - 1);
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= D_RX;
      s_q.crc <= LMC_CRC_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.r_vld = s_q.vld;
  assign link.r_byte = s_q.dout;
  assign reply_busy = s_q.st == D_TX;
endmodule : lmc_dev

// >>> src/lmc_host.sv
// master end: issues the move count read and checks the reply
`timescale 1ns/1ps
module lmc_host
  import lmc_pkg::*;
#(
  parameter int BYTE_GAP = LMC_BYTE_GAP,
  parameter int SILENCE = LMC_SILENCE,
  parameter int TIMEOUT = LMC_TIMEOUT
) (
  input wire logic clock,
  input wire logic rst_n,
  lmc_link_if.host link,
  input wire logic req,
  input wire logic [3:0] axis_no,
  output logic busy,
  output logic done,
  output logic fail,
  output logic [31:0] move_count
);
  if (BYTE_GAP < 1 || SILENCE <= BYTE_GAP || SILENCE > 255
      || TIMEOUT > 255 || TIMEOUT < 1) begin : g_chk
    $error("lmc_host: gap, silence or timeout out of range");
  end

  typedef enum logic [1:0] {H_IDLE, H_TX, H_RX} lmc_hst_t;
  typedef struct packed {
    lmc_hst_t st;
    logic [7:0] addr;
    logic [3:0] tidx;
    logic [7:0] gap;
    logic [15:0] crc;
    logic [8:0][7:0] rbuf;
    logic [3:0] nb;
    logic [7:0] idle;
    logic vld;
    logic [7:0] dout;
    logic done;
    logic fail;
    logic [31:0] cnt;
  } lmc_hstate_t;

  lmc_hstate_t s_q, s_d;
  logic [7:0] tx_byte;
  logic r_ok;

  always_comb begin
    unique case (s_q.tidx)
      4'd0: tx_byte = s_q.addr;
      4'd1: tx_byte = LMC_FUNC_READ;
      4'd2: tx_byte = LMC_REG_HIGH[15:8];
      4'd3: tx_byte = LMC_REG_HIGH[7:0];
      4'd4: tx_byte = LMC_REG_QTY[15:8];
      4'd5: tx_byte = LMC_REG_QTY[7:0];
      4'd6: tx_byte = s_q.crc[7:0];
      default: tx_byte = s_q.crc[15:8];
    endcase
  end

  assign r_ok = s_q.nb == LMC_RESP_LEN && s_q.crc == 16'h0000
    && s_q.rbuf[0] == s_q.addr
    && s_q.rbuf[1] == LMC_FUNC_READ
    && s_q.rbuf[2] == LMC_BYTE_COUNT;

  always_comb begin
    s_d = s_q;
    s_d.vld = 1'b0;
    s_d.done = 1'b0;
    s_d.fail = 1'b0;
    unique case (s_q.st)
      H_IDLE: begin
        if (req) begin
          s_d.st = H_TX;
          s_d.addr = lmc_axis_addr(axis_no);
          s_d.tidx = 4'h0;
          s_d.gap = 8'(SILENCE);
          s_d.crc = LMC_CRC_INIT;
        end
      end
      H_TX: begin
        if (s_q.gap != 8'h00) begin
          s_d.gap = s_q.gap - 8'h01;
        end else begin
          s_d.vld = 1'b1;
          s_d.dout = tx_byte;
          if (s_q.tidx < 4'd6) begin
            s_d.crc = lmc_crc_step(s_q.crc, tx_byte);
          end
          s_d.tidx = s_q.tidx + 4'h1;
          s_d.gap = 8'(BYTE_GAP - 1);
          if (s_q.tidx == LMC_QUERY_LEN - 4'h1) begin
            s_d.st = H_RX;
            s_d.nb = 4'h0;
            s_d.idle = 8'h00;
            s_d.crc = LMC_CRC_INIT;
          end
        end
      end
      H_RX: begin
        if (link.r_vld) begin
          if (s_q.nb < LMC_RESP_LEN) begin
            s_d.rbuf[s_q.nb] = link.r_byte;
          end
          if (s_q.nb != 4'hf) begin
            s_d.nb = s_q.nb + 4'h1;
          end
          s_d.crc = lmc_crc_step(s_q.crc, link.r_byte);
          s_d.idle = 8'h00;
        end else begin
          s_d.idle = s_q.idle + 8'h01;
          // silent device counts as a failed read rather than a hang
          if ((s_q.nb != 4'h0 && s_q.idle == 8'(SILENCE - 1)) ||
              (s_q.nb == 4'h0 && s_q.idle == 8'(TIMEOUT - 1))) begin
            s_d.st = H_IDLE;
            s_d.done = r_ok;
            s_d.fail = !r_ok;
            if (r_ok) begin
              s_d.cnt = {s_q.rbuf[3], s_q.rbuf[4],
                         s_q.rbuf[5], s_q.rbuf[6]};
            end
          end
        end
      end
      default: s_d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.st <= H_IDLE;
      s_q.crc <= LMC_CRC_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.q_vld = s_q.vld;
  assign link.q_byte = s_q.dout;
  assign busy = s_q.st != H_IDLE;
  assign done = s_q.done;
  assign fail = s_q.fail;
  assign move_count = s_q.cnt;
endmodule : lmc_host

// >>> src/lmc_link_if.sv
// byte link between the master end and the controller end
`timescale 1ns/1ps
interface lmc_link_if;
  logic q_vld;
  logic [7:0] q_byte;
  logic r_vld;
  logic [7:0] r_byte;
  modport host (output q_vld, output q_byte, input r_vld, input r_byte);
  modport dev (input q_vld, input q_byte, output r_vld, output r_byte);
endinterface : lmc_link_if

// >>> src/lmc_pkg.sv
// shared constants and helpers for the lifetime move count read link
package lmc_pkg;
  localparam logic [7:0] LMC_FUNC_READ = 8'h03;
  localparam logic [15:0] LMC_REG_HIGH = 16'h8400;
  localparam logic [15:0] LMC_REG_LOW = 16'h8401;
  localparam logic [15:0] LMC_REG_QTY = 16'h0002;
  localparam logic [7:0] LMC_BYTE_COUNT = 8'h04;
  localparam logic [15:0] LMC_CRC_INIT = 16'hffff;
  localparam logic [15:0] LMC_CRC_POLY = 16'ha001;
  localparam logic [3:0] LMC_QUERY_LEN = 4'h8;
  localparam logic [3:0] LMC_RESP_LEN = 4'h9;
  localparam logic [7:0] LMC_ADDR_MIN = 8'h01;
  localparam logic [7:0] LMC_ADDR_MAX = 8'h10;
  // default cycle counts between bytes, for a frame-ending silence and for the reply timeout
  localparam int LMC_BYTE_GAP = 4;
  localparam int LMC_SILENCE = 16;
  localparam int LMC_TIMEOUT = 200;

  function automatic logic [15:0] lmc_crc_step(input logic [15:0] crc,
                                               input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ LMC_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : lmc_crc_step

  function automatic logic [7:0] lmc_axis_addr(input logic [3:0] axis);
    return {4'h0, axis} + LMC_ADDR_MIN;
  endfunction : lmc_axis_addr
endpackage : lmc_pkg

// >>> tb/lmc_monitor.sv
// assertions on the query and reply byte link
`timescale 1ns/1ps
module lmc_monitor #(
  parameter int SILENCE = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic q_vld,
  input wire logic [7:0] q_byte,
  input wire logic r_vld,
  input wire logic [7:0] r_byte
);
  logic [3:0] qn_q;
  logic [3:0] rn_q;
  logic [7:0] idle_q;
  logic [7:0] addr_q;
  logic [3:0] qi;
  // a long idle stretch restarts the query index, as a frame would
  assign qi = (idle_q >= 8'(SILENCE)) ? 4'h0 : qn_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      qn_q <= 4'h0;
      rn_q <= 4'h0;
      idle_q <= 8'h00;
      addr_q <= 8'h00;
    end else begin
      if (q_vld) qn_q <= qi + 4'h1;
      if (q_vld && qi == 4'h0) addr_q <= q_byte;
      if (r_vld) rn_q <= rn_q + 4'h1;
      else if (q_vld) rn_q <= 4'h0;
      if (q_vld) idle_q <= 8'h00;
      else if (idle_q != 8'hff) idle_q <= idle_q + 8'h01;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_query_addr: assert property (q_vld && qi == 4'h0 |->
    q_byte inside {[8'h01:8'h10]}) else $error("query address range");
  a_query_func: assert property (q_vld && qi == 4'h1 |->
    q_byte == 8'h03) else $error("query function code");
  a_query_start: assert property (q_vld && qi == 4'h2 |->
    q_byte == 8'h84) else $error("query start address");
  a_query_qty: assert property (q_vld && qi == 4'h5 |->
    q_byte == 8'h02) else $error("query quantity");
  a_addr_echo: assert property (r_vld && rn_q == 4'h0 |->
    r_byte == addr_q) else $error("reply address not echoed");
  a_reply_func: assert property (r_vld && rn_q == 4'h1 |->
    r_byte == 8'h03) else $error("reply function code");
  a_byte_count: assert property (r_vld && rn_q == 4'h2 |->
    r_byte == 8'h04) else $error("reply byte count");
  a_reply_len: assert property (r_vld |-> rn_q < 4'h9)
    else $error("reply too long");
  a_reply_silence: assert property (r_vld && rn_q == 4'h0 |->
    idle_q >= 8'(SILENCE)) else $error("reply without silence");
  a_half_duplex: assert property (r_vld |-> !q_vld)
    else $error("both directions at once");
endmodule : lmc_monitor

// >>> tb/tb.sv
// self-checking bench for the move count read link
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic [3:0] h_axis = 4'h0;
  logic [3:0] d_axis = 4'h0;
  logic [31:0] count = 32'h0;
  // second end is held at axis 0 with a fixed count; only its query link is driven by the bench
  logic [3:0] d2_axis = 4'h0;
  logic [31:0] d2_count = 32'h0000021f;
  logic busy, done, fail, reply_busy;
  logic [31:0] move_count;
  logic [7:0] qq[$], rq[$];
  int errors = 0;
  int checked = 0;
  int seed = 32'hcde6;
  int r2 = 0;
  int a;
  lmc_link_if lnk();
  lmc_link_if lnk2();
  always #50 clock = ~clock;
  lmc_host lmc_host_inst (
    .clock(clock), .rst_n(rst_n), .link(lnk.host), .req(req),
    .axis_no(h_axis), .busy(busy), .done(done), .fail(fail),
    .move_count(move_count));
  lmc_dev lmc_dev_inst (.clock(clock),
    .rst_n(rst_n), .link(lnk.dev), .axis_no(d_axis),
    .lifetime_move_count(count), .reply_busy(reply_busy));
  // second end fed by hand with one frame with a bad check and one with a good check
  lmc_dev lmc_dev_inst2 (.clock(clock),
    .rst_n(rst_n), .link(lnk2.dev), .axis_no(d2_axis),
    .lifetime_move_count(d2_count), .reply_busy());
  lmc_monitor lmc_monitor_inst (.clock(clock),
    .rst_n(rst_n), .q_vld(lnk.q_vld), .q_byte(lnk.q_byte),
    .r_vld(lnk.r_vld), .r_byte(lnk.r_byte));
  always @(posedge clock) begin
    if (lnk.q_vld) qq.push_back(lnk.q_byte);
    if (lnk.r_vld) rq.push_back(lnk.r_byte);
    if (lnk2.r_vld) r2 = r2 + 1;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [15:0] crc(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (f[i]) begin
      c = c ^ {8'h00, f[i]};
      for (int j = 0; j < 8; j++)
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc
  task automatic frame(input string what, input logic [7:0] e[$], got[$]);
    logic [15:0] c;
    c = crc(e);
    e.push_back(c[7:0]);
    e.push_back(c[15:8]);
    check(what, got.size(), e.size());
    foreach (e[i]) check(what, got[i], e[i]);
  endtask : frame
  task automatic run(input logic [3:0] ah, ad, input logic [31:0] c);
    int n;
    qq.delete();
    rq.delete();
    @(negedge clock);
    h_axis = ah;
    d_axis = ad;
    count = c;
    req = 1'b1;
    @(negedge clock);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && fail !== 1'b1 && n < 400) begin
      @(posedge clock);
      #1 n++;
    end
    if (n >= 400) begin
      errors++;
      wrap_up();
    end
    frame("query", {{4'h0, ah} + 8'h01, 8'h03, 8'h84, 8'h00, 8'h00,
      8'h02}, qq);
    if (ah == ad) begin
      frame("reply", {{4'h0, ad} + 8'h01, 8'h03, 8'h04, c[31:24],
        c[23:16], c[15:8], c[7:0]}, rq);
      check("count", move_count, c);
    end else check("silent", rq.size(), 0);
    check("done", done, ah == ad);
    check("fail", fail, ah != ad);
    check("busy", busy, 0);
    check("dev idle", reply_busy, 0);
    $display("test axis %0d to %0d ended", ah, ad);
  endtask : run
  task automatic send(input logic [7:0] b[$]);
    r2 = 0;
    foreach (b[i]) begin
      @(negedge clock);
      lnk2.q_vld = 1'b1;
      lnk2.q_byte = b[i];
      @(negedge clock);
      lnk2.q_vld = 1'b0;
      lnk2.q_byte = ~b[i];
    end
    repeat (80) @(negedge clock);
  endtask : send
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    lnk2.q_vld = 1'b0;
    lnk2.q_byte = 8'h00;
    repeat (10) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    run(4'h0, 4'h0, 32'h0000021f);
    run(4'hf, 4'hf, 32'hffffffff);
    run(4'h2, 4'h3, 32'h12345678);
    repeat (6) begin
      a = $random(seed);
      run(a[3:0], a[3:0], $random(seed));
    end
    send({8'h01, 8'h03, 8'h84, 8'h00, 8'h00, 8'h02, 8'hec, 8'hfc});
    check("bad check", r2, 0);
    send({8'h01, 8'h03, 8'h84, 8'h00, 8'h00, 8'h02, 8'hec, 8'hfb});
    check("good check", r2, 9);
    $display("test fault frames ended");
    wrap_up();
  end
endmodule : tb
